// [rtl/cps_clock_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module cps_clock_prescaler
	import cps_pkg::*;
#(
	parameter int CFG_X2_POS = CFG_X2_POS_DEF
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] hardware_config_byte_i,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o,
	output logic machine_cycle_o,
	output var cps_periph_ticks_t periph_cycle_o,
	output logic half_osc_o,
	output logic double_speed_o,
	output logic clock_source_select_o
);
	logic [7:0] reload_reg;
	logic [6:0] ctrl_reg;
	logic [7:0] rdata_reg;
	logic half_reg;
	logic x2_eff_reg;
	logic base_tick;
	logic [8:0] pre_cnt_reg;
	logic [8:0] pre_limit;
	logic [7:0] reload_diff;
	logic cpu_en_next;
	logic cpu_en_reg;
	logic [3:0] tick_cnt_reg;
	logic mcycle_next;
	logic mcycle_reg;
	logic cycle_last;
	logic [7:0] cfg_sync;
	logic clk_src_reg;
	logic wr_ctrl;
	logic wr_reload;
	logic [PERIPH_N-1:0] periph_vec;
	cps_boot_state_t boot_reg;

	if (CFG_X2_POS < 0 || CFG_X2_POS > 7) begin : g_bad_pos
		$error("configuration bit position out of range");
	end

	// strap input from the pin
	cps_sync2 #(
		.WIDTH(8)
	) u_cfg_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(hardware_config_byte_i),
		.q_o(cfg_sync)
	);

	assign wr_ctrl = wr_i && (addr_i == CTRL_ADDR); // see R15
	assign wr_reload = wr_i && (addr_i == RELOAD_ADDR); // see R15

	// strap capture after reset release
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			boot_reg <= BOOT_RESET;
		end else begin
			case (boot_reg)
				BOOT_RESET: boot_reg <= BOOT_WAIT;
				BOOT_WAIT: boot_reg <= BOOT_LOAD;
				BOOT_LOAD: boot_reg <= BOOT_RUN;
				BOOT_RUN: boot_reg <= BOOT_RUN;
				default: boot_reg <= BOOT_RESET;
			endcase
		end
	end

	// reload register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reload_reg <= RELOAD_RST; // see R1 see R15
		end else if (wr_reload) begin
			reload_reg <= wdata_i; // see R2
		end
	end

	// control register, bit 7 not stored
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= CTRL_RST; // see R17
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= wdata_i[6:0]; // see R12
			end
			if (boot_reg == BOOT_LOAD) begin
				ctrl_reg[X2_BIT] <= cfg_sync[CFG_X2_POS]; // see R10 see R17
			end
		end
	end

	// register read, data one cycle later
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				CTRL_ADDR: rdata_reg <= {1'b0, ctrl_reg}; // see R14
				RELOAD_ADDR: rdata_reg <= reload_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// clock output source: oscillator
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			clk_src_reg <= 1'b1; // see R6
		end else begin
			clk_src_reg <= 1'b1;
		end
	end

	// oscillator halver
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			half_reg <= 1'b0;
		end else begin
			half_reg <= !half_reg; // see R7
		end
	end

	// mode taken on the halved clock's rising edge
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			x2_eff_reg <= 1'b0;
		end else if (!half_reg) begin
			x2_eff_reg <= ctrl_reg[X2_BIT]; // see R9
		end
	end

	// halver bypassed in double speed
	assign base_tick = x2_eff_reg || half_reg; // see R7

	assign reload_diff = RELOAD_MAX - reload_reg;
	always_comb begin
		if (reload_reg == RELOAD_MAX) begin
			pre_limit = LIMIT_ONE; // see R4
		end else begin
			pre_limit = {reload_diff, 1'b0}; // see R3 see R5
		end
	end

	// >= recovers when a larger reload lands mid-count
	assign cpu_en_next = base_tick && (pre_cnt_reg >= (pre_limit - LIMIT_ONE)); // see R2

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pre_cnt_reg <= 9'h000;
		end else if (base_tick) begin
			if (cpu_en_next) begin
				pre_cnt_reg <= 9'h000;
			end else begin
				pre_cnt_reg <= pre_cnt_reg + LIMIT_ONE;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cpu_en_reg <= 1'b0;
		end else begin
			cpu_en_reg <= cpu_en_next;
		end
	end

	// cpu clock phases within a peripheral cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tick_cnt_reg <= 4'h0;
		end else if (cpu_en_next) begin
			if (tick_cnt_reg == TICK_LAST) begin
				tick_cnt_reg <= 4'h0;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 4'h1;
			end
		end
	end

	// six cpu clocks per machine cycle
	assign mcycle_next = cpu_en_next && ((tick_cnt_reg == TICK_HALF_LAST) || (tick_cnt_reg == TICK_LAST)); // see R8
	assign cycle_last = tick_cnt_reg == TICK_LAST;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mcycle_reg <= 1'b0;
		end else begin
			mcycle_reg <= mcycle_next;
		end
	end

	// one tick generator per peripheral speed bit
	for (genvar i = 0; i < PERIPH_N; i++) begin : g_periph
		cps_periph_tick u_tick (
			.mclk_i(mclk_i),
			.rst_n_i(rst_n_i),
			.mcycle_next_i(mcycle_next),
			.double_speed_i(x2_eff_reg),
			.speed_sel_i(ctrl_reg[PERIPH_LO + i]), // see R12
			.cycle_last_i(cycle_last),
			.tick_o(periph_vec[i])
		);
	end

	assign periph_cycle_o = cps_periph_ticks_t'(periph_vec);
	assign rdata_o = rdata_reg;
	assign cpu_clk_en_o = cpu_en_reg;
	assign periph_clk_en_o = cpu_en_reg;
	assign machine_cycle_o = mcycle_reg;
	assign half_osc_o = half_reg;
	assign double_speed_o = x2_eff_reg;
	assign clock_source_select_o = clk_src_reg;

	// checking helpers
	logic [10:0] gap_cnt_reg;
	logic [10:0] exp_gap;
	logic [10:0] exp_base;
	logic settled_reg;
	logic [2:0] mc_cnt_reg;
	logic x2_pending;
	logic x2_switch_reg;

	assign x2_pending = !half_reg && (ctrl_reg[X2_BIT] != x2_eff_reg);
	assign exp_base = (reload_reg == RELOAD_MAX) ? 11'h001 : 11'((11'h0ff - {3'h0, reload_reg}) << 1);
	assign exp_gap = x2_eff_reg ? exp_base : 11'(exp_base << 1);

	// last pulse of the old mode still in flight after a switch
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			x2_switch_reg <= 1'b0;
		end else begin
			x2_switch_reg <= x2_pending;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			gap_cnt_reg <= 11'h001;
		end else if (cpu_en_reg) begin
			gap_cnt_reg <= 11'h001;
		end else begin
			gap_cnt_reg <= gap_cnt_reg + 11'h001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			settled_reg <= 1'b0;
		end else if (wr_reload || x2_pending || x2_switch_reg) begin
			settled_reg <= 1'b0;
		end else if (cpu_en_reg) begin
			settled_reg <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mc_cnt_reg <= 3'h0;
		end else if (cpu_en_reg) begin
			mc_cnt_reg <= mcycle_reg ? 3'h0 : mc_cnt_reg + 3'h1;
		end
	end

	reload_reset_a: assert property ( // see R1
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> (reload_reg == 8'hff) && (ctrl_reg[6:1] == 6'h00) && !x2_eff_reg
	) else $error("reset values wrong");

	reload_write_a: assert property ( // see R2
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_i && (addr_i == 8'h97) |=> reload_reg == $past(wdata_i)
	) else $error("reload write not stored");

	cpu_period_a: assert property ( // see R3
		@(posedge mclk_i) disable iff (!rst_n_i)
		cpu_en_reg && settled_reg |-> gap_cnt_reg == exp_gap
	) else $error("cpu clock period wrong");

	std_halving_a: assert property ( // see R7
		@(posedge mclk_i) disable iff (!rst_n_i)
		!$past(x2_eff_reg) && !x2_eff_reg && cpu_en_reg |=> !cpu_en_reg
	) else $error("standard mode not halved");

	machine_cycle_a: assert property ( // see R8
		@(posedge mclk_i) disable iff (!rst_n_i)
		mcycle_reg |-> cpu_en_reg && (mc_cnt_reg == 3'h5)
	) else $error("machine cycle not six cpu clocks");

	mode_switch_a: assert property ( // see R9
		@(posedge mclk_i) disable iff (!rst_n_i)
		$changed(x2_eff_reg) |-> half_reg && !$past(half_reg)
	) else $error("mode changed off halved edge");

	std_periph_a: assert property ( // see R11
		@(posedge mclk_i) disable iff (!rst_n_i)
		!$past(x2_eff_reg) |-> periph_vec == {PERIPH_N{mcycle_reg}}
	) else $error("peripheral speed bit active in standard mode");

	slow_watchdog_a: assert property ( // see R13
		@(posedge mclk_i) disable iff (!rst_n_i)
		periph_cycle_o.watchdog && $past(x2_eff_reg) && $past(ctrl_reg[6]) |-> tick_cnt_reg == 4'h0
	) else $error("watchdog slow tick misplaced");

	fast_timer_a: assert property ( // see R16
		@(posedge mclk_i) disable iff (!rst_n_i)
		mcycle_reg && $past(x2_eff_reg) && !$past(ctrl_reg[1]) |-> periph_cycle_o.timer0
	) else $error("timer fast tick missing");

	ctrl_read_a: assert property ( // see R15
		@(posedge mclk_i) disable iff (!rst_n_i)
		rd_i && (addr_i == 8'h8f) |=> rdata_o == {1'b0, $past(ctrl_reg)}
	) else $error("control read wrong");

	clock_source_a: assert property ( // see R6
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(rst_n_i) |-> clock_source_select_o [*4]
	) else $error("oscillator not selected");

	strap_load_a: assert property ( // see R10
		@(posedge mclk_i) disable iff (!rst_n_i)
		(boot_reg == BOOT_LOAD) |=> ctrl_reg[X2_BIT] == $past(hardware_config_byte_i[CFG_X2_POS], 3)
	) else $error("strap not loaded into double speed bit");

	slow_reload_c: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		cpu_en_reg && settled_reg && (reload_reg == 8'h00)
	);

	mode_up_c: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(x2_eff_reg)
	);

	mode_down_c: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		$fell(x2_eff_reg)
	);

	slow_periph_c: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		periph_cycle_o.watchdog && x2_eff_reg && ctrl_reg[6]
	);
endmodule // cps_clock_prescaler
`default_nettype wire

// [rtl/cps_periph_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module cps_periph_tick (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic mcycle_next_i,
	input wire logic double_speed_i,
	input wire logic speed_sel_i,
	input wire logic cycle_last_i,
	output logic tick_o
);
	logic slow;

	// 12 periods unless double speed with the bit clear
	assign slow = double_speed_i && speed_sel_i; // see R11 see R13 see R16

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= mcycle_next_i && (!slow || cycle_last_i); // see R11
		end
	end
endmodule // cps_periph_tick
`default_nettype wire

// [rtl/cps_pkg.sv]
// Function
// R1 - reset loads reload with all ones; cpu and peripheral clocks run at oscillator/2
// R2 - software may write any reload value from ff down to 00
// R3 - reload 00 gives oscillator/1020 standard, oscillator/510 double speed
// R4 - reload ff gives oscillator/2 standard, undivided oscillator double speed
// R5 - other reloads divide by 2*(255-reload) double speed, 4*(255-reload) standard
// R6 - clock source select picks the oscillator after reset
// R7 - standard mode halves the oscillator; double speed bit bypasses the halver
// R8 - machine cycle is 12 oscillator periods standard, 6 double speed
// R9 - double speed changes only on a rising edge of the halved clock
// R10 - reset takes double speed from the hardware configuration byte
// R11 - peripheral speed bits act only in double speed; otherwise 12 periods
// R12 - control bit 0 double speed, bits 1-5 peripheral speeds, bit 6 watchdog
// R13 - watchdog speed clear gives 6 periods, set gives 12, only in double speed
// R14 - software keeps reserved control bit 7 at zero
// R15 - reload at 97h resets to ff; control at 8fh; no bit addressing
// R16 - timer, serial and counter array speed: clear 6, set 12, double speed only
// R17 - after power-up double speed from configuration byte, other control bits zero
package cps_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h8f; // see R15
	localparam logic [7:0] RELOAD_ADDR = 8'h97; // see R15
	localparam logic [7:0] RELOAD_RST = 8'hff;
	localparam logic [7:0] RELOAD_MAX = 8'hff;
	localparam logic [6:0] CTRL_RST = 7'h00;
	localparam int X2_BIT = 0;
	localparam int PERIPH_LO = 1;
	localparam int PERIPH_N = 6;
	localparam int CFG_X2_POS_DEF = 0;
	localparam logic [3:0] TICK_HALF_LAST = 4'h5;
	localparam logic [3:0] TICK_LAST = 4'hb;
	localparam logic [8:0] LIMIT_ONE = 9'h001;

	// bit order follows control bits 6..1
	typedef struct packed {
		logic watchdog;
		logic counter_array;
		logic serial_port;
		logic timer2;
		logic timer1;
		logic timer0;
	} cps_periph_ticks_t;

	typedef enum logic [1:0] {
		BOOT_RESET = 2'b00,
		BOOT_WAIT = 2'b01,
		BOOT_LOAD = 2'b10,
		BOOT_RUN = 2'b11
	} cps_boot_state_t;
endpackage

// [rtl/cps_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module cps_sync2 #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_reg;

	if (WIDTH < 1) begin : g_bad_width
		$error("sync width must be positive");
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule // cps_sync2
`default_nettype wire

// [testbench/test_cps_clock_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module test_cps_clock_prescaler import cps_pkg::*;;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] hardware_config_byte_i = 8'h00;
	logic [7:0] rdata_o;
	logic cpu_clk_en_o;
	logic periph_clk_en_o;
	logic machine_cycle_o;
	cps_periph_ticks_t periph_cycle_o;
	logic half_osc_o;
	logic double_speed_o;
	logic clock_source_select_o;
	logic [8:0] mon;
	int bad_count = 0;
	int num_checks = 0;
	int i;
	logic [7:0] v;
	assign mon = {periph_clk_en_o, periph_cycle_o, machine_cycle_o, cpu_clk_en_o};

	cps_clock_prescaler cps_clock_prescaler_inst (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.hardware_config_byte_i(hardware_config_byte_i),
		.cpu_clk_en_o(cpu_clk_en_o),
		.periph_clk_en_o(periph_clk_en_o),
		.machine_cycle_o(machine_cycle_o),
		.periph_cycle_o(periph_cycle_o),
		.half_osc_o(half_osc_o),
		.double_speed_o(double_speed_o),
		.clock_source_select_o(clock_source_select_o)
	);

	initial begin
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// cpu and peripheral enables run together
	always @(negedge mclk_i) begin
		if (rst_n_i === 1'b1) begin
			check("periph_clk_en", periph_clk_en_o, cpu_clk_en_o);
		end
	end

	task automatic do_reset();
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		d = rdata_o;
	endtask

	task automatic wait_pulse(input int sel, output int n);
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (mon[sel] !== 1'b1 && n < 4000);
		if (n >= 4000) begin
			bad_count++;
			$display("mismatch pulse_wait expected pulse seen none");
			end_of_test();
		end
	endtask

	// skip the irregular period after a change, then measure one
	task automatic per(input int sel, input int exp, input string name);
		int n;
		wait_pulse(sel, n);
		wait_pulse(sel, n);
		wait_pulse(sel, n);
		check(name, n[15:0], exp[15:0]);
	endtask

	task automatic mode_wait(input logic exp);
		int n;
		n = 0;
		@(negedge mclk_i);
		while (double_speed_o !== exp && n < 4) begin
			@(negedge mclk_i);
			n++;
		end
		check("double_speed", double_speed_o, exp);
		check("half_osc_at_switch", half_osc_o, 1'b1);
		if (double_speed_o !== exp) begin
			end_of_test();
		end
	endtask

	task automatic rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp, input string name);
		reg_write(a, d);
		reg_read(a, v);
		check(name, v, exp);
	endtask

	initial begin
		do_reset();
		reg_read(RELOAD_ADDR, v);
		check("reload_reset", v, 8'hff);
		@(negedge mclk_i);
		check("rdata_after", rdata_o, 8'h00);
		reg_read(CTRL_ADDR, v);
		check("ctrl_reset", v, 8'h00);
		check("source_sel", clock_source_select_o, 1'b1);
		check("std_mode", double_speed_o, 1'b0);
		per(0, 2, "cpu_std_ff");
		per(1, 12, "mcycle_std");
		per(8, 2, "periph_en_std");
		$display("test reset done");

		rw(RELOAD_ADDR, 8'h00, 8'h00, "reload_00");
		per(0, 1020, "cpu_std_00");
		rw(RELOAD_ADDR, 8'hfe, 8'hfe, "reload_fe");
		per(0, 4, "cpu_std_fe");
		rw(RELOAD_ADDR, 8'h80, 8'h80, "reload_80");
		per(0, 508, "cpu_std_80");
		rw(RELOAD_ADDR, 8'hff, 8'hff, "reload_ff");
		per(0, 2, "cpu_std_back");
		$display("test std reload done");

		reg_write(8'h90, 8'h55);
		reg_read(8'h90, v);
		check("unmapped_read", v, 8'h00);
		reg_read(RELOAD_ADDR, v);
		check("reload_kept", v, 8'hff);
		$display("test unmapped done");

		rw(CTRL_ADDR, 8'h7e, 8'h7e, "ctrl_7e");
		check("bits_no_x2", double_speed_o, 1'b0);
		for (i = 2; i < 8; i++) begin
			per(i, 12, "periph_std");
		end
		reg_write(CTRL_ADDR, 8'h7f);
		mode_wait(1'b1);
		reg_read(CTRL_ADDR, v);
		check("ctrl_all_set", v, 8'h7f);
		per(0, 1, "cpu_x2_ff");
		per(1, 6, "mcycle_x2");
		for (i = 2; i < 8; i++) begin
			per(i, 12, "periph_x2_set");
		end
		reg_write(CTRL_ADDR, 8'h01);
		for (i = 2; i < 8; i++) begin
			per(i, 6, "periph_x2_clear");
		end
		rw(RELOAD_ADDR, 8'h00, 8'h00, "reload_x2_00");
		per(0, 510, "cpu_x2_00");
		per(8, 510, "periph_en_x2_00");
		rw(RELOAD_ADDR, 8'h80, 8'h80, "reload_x2_80");
		per(0, 254, "cpu_x2_80");
		rw(RELOAD_ADDR, 8'hff, 8'hff, "reload_x2_ff");
		reg_write(CTRL_ADDR, 8'h00);
		mode_wait(1'b0);
		per(0, 2, "cpu_std_again");
		per(1, 12, "mcycle_std_again");
		$display("test mode done");

		@(posedge mclk_i);
		hardware_config_byte_i <= 8'h01;
		do_reset();
		reg_read(CTRL_ADDR, v);
		check("ctrl_strap", v, 8'h01);
		reg_read(RELOAD_ADDR, v);
		check("reload_strap", v, 8'hff);
		check("strap_mode", double_speed_o, 1'b1);
		per(0, 1, "cpu_strap");
		$display("test strap done");
		end_of_test();
	end
endmodule // test_cps_clock_prescaler
`default_nettype wire
